// file: pkg/mpc_consts.svh
// constants for the strap-configured media-independent port pair
// =====================================================================
`ifndef MPC_CONSTS_SVH
`define MPC_CONSTS_SVH

// =====================================================================
// mode strap codes
`define MPC_M_SWS_R_LO 4'h0
`define MPC_M_SWS_R_HI 4'h1
`define MPC_M_SWS_R_FD 4'h2
`define MPC_M_RSVD_A 4'h3
`define MPC_M_SWS_F_LO 4'h4
`define MPC_M_SWS_F_HI 4'h5
`define MPC_M_SWS_F_FD 4'h6
`define MPC_M_RSVD_B 4'h7
`define MPC_M_MAC_HD 4'h8
`define MPC_M_RMII_HD 4'h9
`define MPC_M_MAC_FD 4'hA
`define MPC_M_RMII_FD 4'hB
`define MPC_M_PHY10_HD 4'hC
`define MPC_M_PHY100_HD 4'hD
`define MPC_M_PHY10_FD 4'hE
`define MPC_M_PHY100_FD 4'hF

// =====================================================================
// clock rates in kHz and derived half periods in core cycles
`define MPC_CORE_KHZ 100000
`define MPC_MII10_KHZ 2500
`define MPC_MII100_KHZ 25000
`define MPC_RMII_KHZ 50000
`define MPC_SWS_KHZ 10000
`define MPC_MAC_MAX_KHZ 25000
`define MPC_HP_MII10 (`MPC_CORE_KHZ / (2 * `MPC_MII10_KHZ))
`define MPC_HP_MII100 (`MPC_CORE_KHZ / (2 * `MPC_MII100_KHZ))
`define MPC_HP_RMII (`MPC_CORE_KHZ / (2 * `MPC_RMII_KHZ))
`define MPC_HP_SWS (`MPC_CORE_KHZ / (2 * `MPC_SWS_KHZ))

// =====================================================================
// startup
`define MPC_STRAP_SETTLE 3
`define MPC_SYNC_W 28

`endif

// file: pkg/mpc_pkg.sv
// types and mode decoding for the media-independent port pair
`include "mpc_consts.svh"
package mpc_pkg;

  // =====================================================================
  // interface kinds
  typedef enum logic [2:0] {KIND_SWS, KIND_MII_MAC, KIND_RMII, KIND_MII_PHY, KIND_RSVD} mpc_kind_t;

  typedef enum logic {PH_SETTLE, PH_RUN} mpc_phase_t;

  typedef struct packed {
    mpc_kind_t kind;
    logic full_dup;
    logic fall_edge;
    logic col_high;
    logic [4:0] half_per;
  } mpc_cfg_t;

  // =====================================================================
  // strap code to configuration
  function automatic mpc_cfg_t mpc_decode(input logic [3:0] m);
    mpc_cfg_t c;
    c.kind = KIND_RSVD;
    c.full_dup = 1'b0;
    c.fall_edge = m[2];
    c.col_high = 1'b1;
    c.half_per = 5'(`MPC_HP_SWS);
    case (m)
      `MPC_M_SWS_R_LO, `MPC_M_SWS_F_LO:
      begin
        c.kind = KIND_SWS;
        c.col_high = 1'b0;
      end
      `MPC_M_SWS_R_HI, `MPC_M_SWS_F_HI: c.kind = KIND_SWS;
      `MPC_M_SWS_R_FD, `MPC_M_SWS_F_FD:
      begin
        c.kind = KIND_SWS;
        c.full_dup = 1'b1;
      end
      `MPC_M_MAC_HD, `MPC_M_MAC_FD:
      begin
        c.kind = KIND_MII_MAC;
        c.full_dup = m[1];
        c.fall_edge = 1'b0;
      end
      `MPC_M_RMII_HD, `MPC_M_RMII_FD:
      begin
        c.kind = KIND_RMII;
        c.full_dup = m[1];
        c.fall_edge = 1'b0;
        c.half_per = 5'(`MPC_HP_RMII);
      end
      `MPC_M_PHY10_HD, `MPC_M_PHY10_FD, `MPC_M_PHY100_HD, `MPC_M_PHY100_FD:
      begin
        c.kind = KIND_MII_PHY;
        c.full_dup = m[1];
        c.fall_edge = 1'b0;
        c.half_per = m[0] ? 5'(`MPC_HP_MII100) : 5'(`MPC_HP_MII10);
      end
      default: c.kind = KIND_RSVD;
    endcase
    return c;
  endfunction

  // data bits moved per link clock edge
  function automatic logic [2:0] mpc_sym_w(input mpc_kind_t k);
    case (k)
      KIND_SWS: return 3'h1;
      KIND_RMII: return 3'h2;
      default: return 3'h4;
    endcase
  endfunction

  // keep the low w bits of a nibble
  function automatic logic [3:0] mpc_low(input logic [3:0] d, input logic [2:0] w);
    case (w)
      3'h1: return d & 4'h1;
      3'h2: return d & 4'h3;
      default: return d;
    endcase
  endfunction

endpackage

// file: pkg/mpc_clk_if.sv
// carrier between a port and its link clock generator
`timescale 1ns/1ps
interface mpc_clk_if;
  logic run; // generator enabled
  logic [4:0] half_per; // half period in core cycles
  logic clk; // generated link clock level
  logic rise; // pulse with the rising edge
  logic fall; // pulse with the falling edge
  modport gen (input run, input half_per, output clk, output rise, output fall);
  modport user (output run, output half_per, input clk, input rise, input fall);
endinterface

// file: core/mpc_sync.sv
// two-flop synchroniser for pins from outside the core clock domain
`timescale 1ns/1ps
module mpc_sync
#(
  parameter int W = 1
)
(
  input wire logic core_clk, // core clock
  input wire logic rstn, // async reset, active low
  input wire logic [W-1:0] async_in, // raw pin levels
  output logic [W-1:0] sync_out // synchronised levels
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // =====================================================================
  // first stage feeds only the second stage
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule

// file: core/mpc_clkgen.sv
// link clock divider for the modes in which the device drives the clocks
`timescale 1ns/1ps
module mpc_clkgen
(
  input wire logic core_clk, // core clock
  input wire logic rstn, // async reset, active low
  mpc_clk_if.gen gen // divider control and outputs
);
  logic [4:0] cnt_q;
  logic clk_q;
  logic rise_q;
  logic fall_q;

  // =====================================================================
  // toggle every half period; edge pulses line up with the new level
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_q <= 5'h00;
      clk_q <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end
    else if (!gen.run)
    begin
      cnt_q <= 5'h00;
      clk_q <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end
    else if (cnt_q == 5'(gen.half_per - 5'h01))
    begin
      cnt_q <= 5'h00;
      clk_q <= ~clk_q;
      rise_q <= ~clk_q;
      fall_q <= clk_q;
    end
    else
    begin
      cnt_q <= 5'(cnt_q + 5'h01);
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end
  end

  assign gen.clk = clk_q;
  assign gen.rise = rise_q;
  assign gen.fall = fall_q;
endmodule

// file: core/mpc_top.sv
// two strap-configured media-independent ports: serial, reduced, forward and reverse MII
`timescale 1ns/1ps
`include "mpc_consts.svh"
module mpc_top
  import mpc_pkg::*;
(
  input wire logic core_clk, // 100 MHz core clock
  input wire logic rstn, // async reset, active low
  input wire logic sixth_port_iface_enable, // strap, high enables sixth port
  input wire logic fifth_port_iface_disable, // strap, high selects internal phy
  input wire logic [1:0] port_rx_side_clock_i, // rx-side clock pin level
  output logic [1:0] port_rx_side_clock_o, // rx-side clock drive
  output logic [1:0] port_rx_side_clock_oe_n, // low while driven
  input wire logic [1:0] port_tx_side_clock_i, // tx-side clock pin level
  output logic [1:0] port_tx_side_clock_o, // tx-side clock drive
  output logic [1:0] port_tx_side_clock_oe_n, // low while driven
  input wire logic [1:0][3:0] port_input_i, // input data, bit0 serial, pair in [1:0]
  input wire logic [1:0] port_input_valid_i, // input data valid
  input wire logic [1:0][3:0] tx_data_mode_strap_i, // strap levels on data pins
  output logic [1:0][3:0] tx_data_mode_strap_o, // output data
  output logic [1:0] tx_data_mode_strap_oe_n, // low while driven
  output logic [1:0] port_output_valid_o, // output data valid
  input wire logic [1:0] port_crs_i, // carrier sense from partner phy
  output logic [1:0] port_crs_o, // carrier sense toward partner mac
  output logic [1:0] port_crs_oe_n, // low while driven
  input wire logic [1:0] port_col_i, // collision from partner phy
  output logic [1:0] port_col_o, // collision toward partner mac
  output logic [1:0] port_col_oe_n, // low while driven
  input wire logic [1:0] mac_tx_valid, // internal mac nibble waiting
  input wire logic [1:0][3:0] mac_tx_nibble, // internal mac nibble
  output logic [1:0] mac_tx_ready, // pulse, nibble taken
  output logic [1:0] mac_rx_valid, // pulse, nibble received
  output logic [1:0][3:0] mac_rx_nibble, // received nibble
  output logic [1:0] mac_rx_dv, // receive frame in progress
  output logic [1:0] mac_crs, // carrier seen by internal mac
  output logic [1:0] mac_col, // collision seen by internal mac
  output logic [1:0][3:0] status_mode, // latched strap code
  output logic [1:0] status_iface_on, // interface enabled and code valid
  output logic [1:0] status_reserved, // reserved code latched
  output logic [1:0] status_full_duplex, // latched duplex
  output logic fifth_port_internal_phy // fifth port runs its copper phy
);

  // =====================================================================
  // synchronisers: straps, then per port clocks, valid, data, crs, col
  logic [`MPC_SYNC_W-1:0] raw_s;
  logic [`MPC_SYNC_W-1:0] syn_s;

  assign raw_s = {port_col_i, port_crs_i, port_input_i, port_input_valid_i,
                  port_tx_side_clock_i, port_rx_side_clock_i,
                  tx_data_mode_strap_i, sixth_port_iface_enable, fifth_port_iface_disable};

  mpc_sync #(.W(`MPC_SYNC_W)) u_sync (
    .core_clk (core_clk),
    .rstn (rstn),
    .async_in (raw_s),
    .sync_out (syn_s)
  );

  logic dis5_s;
  logic en6_s;
  logic [1:0][3:0] strap_s;
  logic [1:0] rxc_s;
  logic [1:0] txc_s;
  logic [1:0] dv_s;
  logic [1:0][3:0] din_s;
  logic [1:0] crs_s;
  logic [1:0] col_s;

  assign dis5_s = syn_s[0];
  assign en6_s = syn_s[1];
  assign strap_s = syn_s[9:2];
  assign rxc_s = syn_s[11:10];
  assign txc_s = syn_s[13:12];
  assign dv_s = syn_s[15:14];
  assign din_s = syn_s[23:16];
  assign crs_s = syn_s[25:24];
  assign col_s = syn_s[27:26];

  // =====================================================================
  // startup: let the synchronisers fill, then latch the straps once
  mpc_phase_t phase_q;
  logic [1:0] settle_q;
  logic capture;

  assign capture = (phase_q == PH_SETTLE) && (settle_q == 2'(`MPC_STRAP_SETTLE - 1));

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      phase_q <= PH_SETTLE;
      settle_q <= 2'h0;
    end
    else
    begin
      case (phase_q)
        PH_SETTLE:
        begin
          if (capture)
            phase_q <= PH_RUN;
          settle_q <= 2'(settle_q + 2'h1);
        end
        PH_RUN: phase_q <= PH_RUN;
        default: phase_q <= PH_SETTLE;
      endcase
    end
  end

  // fifth port falls back to the internal phy when its strap is high
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      fifth_port_internal_phy <= 1'b0;
    else if (capture)
      fifth_port_internal_phy <= dis5_s;
  end

  // =====================================================================
  // per port logic; each port owns its mode and state
  genvar p;
  generate
    for (p = 0; p < 2; p++)
    begin : g_port
      mpc_cfg_t cfg_q;
      mpc_cfg_t cfg_d;
      logic [3:0] mode_q;
      logic en_q;
      logic live_q;
      logic phy_kind;
      logic [2:0] w;
      logic tx_edge;
      logic rx_edge;
      logic rxc_p_q;
      logic txc_p_q;
      logic [3:0] tx_sh_q;
      logic [2:0] tx_left_q;
      logic tx_on_q;
      logic [3:0] tx_out_q;
      logic tx_rdy_q;
      logic [3:0] rx_sh_q;
      logic [2:0] rx_cnt_q;
      logic rx_on_q;
      logic rx_vld_q;
      logic [3:0] rx_nib_q;
      logic coll;
      logic crs_q;
      logic col_q;
      logic mcrs_q;
      logic mcol_q;
      logic [5:0] oe_n_q;

      mpc_clk_if cif ();

      mpc_clkgen u_gen (
        .core_clk (core_clk),
        .rstn (rstn),
        .gen (cif.gen)
      );

      // one decode feeds both the latch and the liveness test
      assign cfg_d = mpc_decode(strap_s[p]);

      // straps latched once after release, never again until reset
      always_ff @(posedge core_clk or negedge rstn)
      begin
        if (!rstn)
        begin
          mode_q <= 4'h0;
          cfg_q <= '{KIND_RSVD, 1'b0, 1'b0, 1'b1, 5'(`MPC_HP_SWS)};
          en_q <= 1'b0;
          live_q <= 1'b0;
        end
        else if (capture)
        begin
          mode_q <= strap_s[p];
          cfg_q <= cfg_d;
          en_q <= (p == 0) ? ~dis5_s : en6_s;
          // a reserved code leaves the port dead until next reset
          live_q <= ((p == 0) ? ~dis5_s : en6_s) &&
                    (cfg_d.kind != KIND_RSVD);
        end
      end

      assign phy_kind = live_q && (cfg_q.kind != KIND_MII_MAC);
      assign w = mpc_sym_w(cfg_q.kind);
      assign cif.run = phy_kind;
      assign cif.half_per = cfg_q.half_per;

      // previous synced clock levels for edge detection in mac mode
      always_ff @(posedge core_clk or negedge rstn)
      begin
        if (!rstn)
        begin
          rxc_p_q <= 1'b0;
          txc_p_q <= 1'b0;
        end
        else
        begin
          rxc_p_q <= rxc_s[p];
          txc_p_q <= txc_s[p];
        end
      end

      // in mac mode each direction follows its own clock; partner clocks need 4 samples a period
      always_comb
      begin
        if (cfg_q.kind == KIND_MII_MAC)
        begin
          tx_edge = live_q && txc_s[p] && !txc_p_q;
          rx_edge = live_q && rxc_s[p] && !rxc_p_q;
        end
        else
        begin
          // drive on the inactive edge, sample on the active one
          tx_edge = phy_kind && (cfg_q.fall_edge ? cif.rise : cif.fall);
          rx_edge = phy_kind && (cfg_q.fall_edge ? cif.fall : cif.rise);
        end
      end

      // =====================================================================
      // transmit: nibbles from the internal mac, shifted out w bits per edge
      always_ff @(posedge core_clk or negedge rstn)
      begin
        if (!rstn)
        begin
          tx_sh_q <= 4'h0;
          tx_left_q <= 3'h0;
          tx_on_q <= 1'b0;
          tx_out_q <= 4'h0;
          tx_rdy_q <= 1'b0;
        end
        else
        begin
          tx_rdy_q <= 1'b0;
          if (!live_q)
          begin
            tx_on_q <= 1'b0;
            tx_out_q <= 4'h0;
            tx_left_q <= 3'h0;
          end
          else if (tx_edge && tx_left_q == 3'h0)
          begin
            if (mac_tx_valid[p])
            begin
              tx_out_q <= mpc_low(mac_tx_nibble[p], w);
              tx_sh_q <= 4'(mac_tx_nibble[p] >> w);
              tx_left_q <= 3'(3'h4 - w);
              tx_on_q <= 1'b1;
              tx_rdy_q <= 1'b1;
            end
            else
            begin
              tx_out_q <= 4'h0;
              tx_on_q <= 1'b0;
            end
          end
          else if (tx_edge)
          begin
            tx_out_q <= mpc_low(tx_sh_q, w);
            tx_sh_q <= 4'(tx_sh_q >> w);
            tx_left_q <= 3'(tx_left_q - w);
          end
        end
      end

      // =====================================================================
      // receive: w bits per active edge, lsb first, gathered into nibbles
      always_ff @(posedge core_clk or negedge rstn)
      begin
        if (!rstn)
        begin
          rx_sh_q <= 4'h0;
          rx_cnt_q <= 3'h0;
          rx_on_q <= 1'b0;
          rx_vld_q <= 1'b0;
          rx_nib_q <= 4'h0;
        end
        else
        begin
          rx_vld_q <= 1'b0;
          if (!live_q)
          begin
            rx_on_q <= 1'b0;
            rx_cnt_q <= 3'h0;
          end
          else if (rx_edge && dv_s[p])
          begin
            rx_on_q <= 1'b1;
            if (3'(rx_cnt_q + w) == 3'h4)
            begin
              rx_nib_q <= 4'((rx_sh_q >> w) | 4'(mpc_low(din_s[p], w) << 3'(3'h4 - w)));
              rx_vld_q <= 1'b1;
              rx_cnt_q <= 3'h0;
            end
            else
            begin
              rx_sh_q <= 4'((rx_sh_q >> w) | 4'(mpc_low(din_s[p], w) << 3'(3'h4 - w)));
              rx_cnt_q <= 3'(rx_cnt_q + w);
            end
          end
          else if (rx_edge)
          begin
            // trailing odd bits are dropped with the frame
            rx_on_q <= 1'b0;
            rx_cnt_q <= 3'h0;
          end
        end
      end

      // collision only matters in half duplex
      assign coll = !cfg_q.full_dup && tx_on_q && rx_on_q;

      // =====================================================================
      // carrier and collision toward the partner and the internal mac
      always_ff @(posedge core_clk or negedge rstn)
      begin
        if (!rstn)
        begin
          crs_q <= 1'b0;
          col_q <= 1'b0;
          mcrs_q <= 1'b0;
          mcol_q <= 1'b0;
        end
        else if (!live_q)
        begin
          crs_q <= 1'b0;
          col_q <= 1'b0;
          mcrs_q <= 1'b0;
          mcol_q <= 1'b0;
        end
        else if (cfg_q.kind == KIND_MII_MAC)
        begin
          mcrs_q <= crs_s[p];
          mcol_q <= col_s[p] && !cfg_q.full_dup;
        end
        else
        begin
          // carrier follows tx activity, and rx activity in half duplex, not the output clock
          crs_q <= tx_on_q || (!cfg_q.full_dup && rx_on_q);
          col_q <= cfg_q.col_high ? coll : !coll;
          mcrs_q <= tx_on_q || rx_on_q;
          mcol_q <= coll;
        end
      end

      // =====================================================================
      // pin enables: data/strap pins float in reset, drive once latched if the port is enabled
      // order: data, rxclk, txclk, crs, col, spare
      always_ff @(posedge core_clk or negedge rstn)
      begin
        if (!rstn)
          oe_n_q <= 6'h3F;
        else if (phase_q == PH_RUN)
        begin
          oe_n_q[0] <= !en_q;
          oe_n_q[1] <= !phy_kind;
          oe_n_q[2] <= !(phy_kind && cfg_q.kind != KIND_RMII);
          oe_n_q[3] <= !phy_kind;
          oe_n_q[4] <= !phy_kind;
          oe_n_q[5] <= 1'b1;
        end
      end

      assign port_rx_side_clock_o[p] = cif.clk;
      assign port_tx_side_clock_o[p] = cif.clk;
      assign port_rx_side_clock_oe_n[p] = oe_n_q[1];
      assign port_tx_side_clock_oe_n[p] = oe_n_q[2];
      assign tx_data_mode_strap_o[p] = tx_out_q;
      assign tx_data_mode_strap_oe_n[p] = oe_n_q[0];
      assign port_output_valid_o[p] = tx_on_q;
      assign port_crs_o[p] = crs_q;
      assign port_crs_oe_n[p] = oe_n_q[3];
      assign port_col_o[p] = col_q;
      assign port_col_oe_n[p] = oe_n_q[4];
      assign mac_tx_ready[p] = tx_rdy_q;
      assign mac_rx_valid[p] = rx_vld_q;
      assign mac_rx_nibble[p] = rx_nib_q;
      assign mac_rx_dv[p] = rx_on_q;
      assign mac_crs[p] = mcrs_q;
      assign mac_col[p] = mcol_q;
      // status shows the latched state of the port
      assign status_mode[p] = mode_q;
      assign status_iface_on[p] = live_q;
      assign status_reserved[p] = en_q && !live_q;
      assign status_full_duplex[p] = cfg_q.full_dup;
    end
  endgenerate

endmodule

// file: testbench/mpc_top_sva.sv
// assertion checker for the media-independent port pair
`timescale 1ns/1ps
module mpc_top_sva
(
  input wire logic core_clk, // core clock
  input wire logic rstn, // async reset, active low
  input wire logic sixth_port_iface_enable, // strap
  input wire logic fifth_port_iface_disable, // strap
  input wire logic [1:0] port_rx_side_clock_o, // clock drive
  input wire logic [1:0] port_rx_side_clock_oe_n, // clock enable
  input wire logic [1:0][3:0] tx_data_mode_strap_i, // strap levels
  input wire logic [1:0][3:0] tx_data_mode_strap_o, // data drive
  input wire logic [1:0] tx_data_mode_strap_oe_n, // data enable
  input wire logic [1:0] port_output_valid_o, // data valid
  input wire logic [1:0] port_crs_o, // carrier out
  input wire logic [1:0] port_col_o, // collision out
  input wire logic [1:0] mac_tx_ready, // nibble taken
  input wire logic [1:0][3:0] status_mode, // latched code
  input wire logic [1:0] status_iface_on, // enabled
  input wire logic [1:0] status_reserved, // reserved code
  input wire logic fifth_port_internal_phy // copper phy
);
  logic [2:0] up_q;
  wire logic on0 = status_iface_on[0] && up_q == 3'h7;
  wire logic sws = on0 && !status_mode[0][3];
  wire logic ck = port_rx_side_clock_o[0];
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // =====================================================================
  // edges since reset release, saturating so checks start after capture
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      up_q <= 3'h0;
    else if (up_q != 3'h7)
      up_q <= up_q + 3'h1;
  end
  sequence hi2_s; ck [*2]; endsequence
  sequence lo2_s; !ck [*2]; endsequence
  // =====================================================================
  float_pins_a: assert property (up_q < 3'h3 |-> &tx_data_mode_strap_oe_n)
    else $error("data pins driven before capture");
  mode_capture_a: assert property (up_q == 3'h5 |->
    status_mode == $past(tx_data_mode_strap_i, 3))
    else $error("latched mode differs from straps");
  mode_hold_a: assert property (up_q == 3'h7 |-> $stable(status_mode))
    else $error("latched mode changed");
  fifth_phy_a: assert property (up_q > 3'h4 |-> fifth_port_internal_phy
    == fifth_port_iface_disable && !(status_iface_on[0] && fifth_port_iface_disable))
    else $error("fifth port selection wrong");
  sixth_off_a: assert property (up_q > 3'h4 && !sixth_port_iface_enable |->
    !status_iface_on[1] && port_rx_side_clock_oe_n[1] && tx_data_mode_strap_oe_n[1])
    else $error("sixth port active while disabled");
  rsvd_quiet_a: assert property (status_reserved[0] |-> status_mode[0][1:0] == 2'h3
    && !status_mode[0][3] && tx_data_mode_strap_o[0] == 4'h0 && !mac_tx_ready[0])
    else $error("reserved code not quiet");
  rmii_clk_a: assert property (on0 && status_mode[0][3:2] == 2'h2 && status_mode[0][0]
    |-> !port_rx_side_clock_oe_n[0] && ck != $past(ck))
    else $error("reduced clock not toggling each cycle");
  fast_clk_a: assert property (on0 && status_mode[0][3:2] == 2'h3 && status_mode[0][0]
    && $rose(ck) |-> hi2_s ##1 lo2_s ##1 ck)
    else $error("fast clock period wrong");
  crs_valid_a: assert property (sws && $rose(port_output_valid_o[0]) |-> ##[0:1] port_crs_o[0])
    else $error("carrier missing on serial output");
  col_level_a: assert property (sws && !status_mode[0][1] && !port_output_valid_o[0]
    && !$past(port_output_valid_o[0]) |-> port_col_o[0] == !status_mode[0][0])
    else $error("idle collision level wrong");
endmodule
bind mpc_top mpc_top_sva i_sva (.core_clk, .rstn, .sixth_port_iface_enable,
  .fifth_port_iface_disable, .port_rx_side_clock_o, .port_rx_side_clock_oe_n,
  .tx_data_mode_strap_i, .tx_data_mode_strap_o, .tx_data_mode_strap_oe_n,
  .port_output_valid_o, .port_crs_o, .port_col_o, .mac_tx_ready, .status_mode,
  .status_iface_on, .status_reserved, .fifth_port_internal_phy);

// file: testbench/mpc_far_model.sv
// far-side model: strap resistors, forward-mode clock and a loopback partner
`timescale 1ns/1ps
module mpc_far_model
(
  input wire logic run, // clock runs only inside frames
  input wire logic [1:0][3:0] strap, // strap resistor levels
  input wire logic [1:0] ck_o, // device clock drive
  input wire logic [1:0] ck_oe_n, // device clock enable
  input wire logic [1:0][3:0] d_o, // device data drive
  input wire logic [1:0] d_oe_n, // device data enable
  input wire logic [1:0] dv_o, // device data valid
  output logic [1:0] ck_i, // resolved clock pins
  output logic [1:0][3:0] d_i, // resolved data pins
  output logic [1:0][3:0] din // looped data toward device
);
  logic lclk;
  // partner clock, phase unrelated to core, frozen between frames
  initial
  begin
    lclk = 1'b0;
    #37;
    forever #80 lclk = run ? ~lclk : lclk;
  end
  // resolve pins; idle loop data inverted so stale bits never pass
  always_comb
  begin
    ck_i = (ck_oe_n & {2{lclk}}) | (~ck_oe_n & ck_o);
    for (int p = 0; p < 2; p++)
    begin
      d_i[p] = d_oe_n[p] ? strap[p] : d_o[p];
      din[p] = dv_o[p] ? d_o[p] : ~d_o[p];
    end
  end
endmodule

// file: testbench/test_mpc_top.sv
// self-checking bench for the media-independent port pair
`timescale 1ns/1ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin bad_count++; \
  $display("Error %s exp %h got %h", n, e, a); end end
module test_mpc_top;
  logic core_clk, rstn, en6, dis5, run, int_phy;
  logic [1:0][3:0] strap, din, d_i, d_o, tx_nib, rx_nib, st_mode;
  logic [1:0] ck_i, ck_o, ck_oe, tck_i, tck_o, tck_oe, d_oe, dv_o, crs_o, crs_oe;
  logic [1:0] col_o, col_oe, tx_v, tx_rdy, rx_v, on, rsv, fd;
  logic [3:0] q[$];
  logic [3:0] exp;
  int bad_count, checked, n;
  mpc_top i_dut (.core_clk(core_clk), .rstn(rstn), .sixth_port_iface_enable(en6),
    .fifth_port_iface_disable(dis5), .port_rx_side_clock_i(ck_i), .port_rx_side_clock_o(ck_o),
    .port_rx_side_clock_oe_n(ck_oe), .port_tx_side_clock_i(tck_i), .port_tx_side_clock_o(tck_o),
    .port_tx_side_clock_oe_n(tck_oe), .port_input_i(din), .port_input_valid_i(dv_o),
    .tx_data_mode_strap_i(d_i), .tx_data_mode_strap_o(d_o), .tx_data_mode_strap_oe_n(d_oe),
    .port_output_valid_o(dv_o), .port_crs_i(crs_oe & dv_o | ~crs_oe & crs_o),
    .port_crs_o(crs_o), .port_crs_oe_n(crs_oe), .port_col_i(~col_oe & col_o),
    .port_col_o(col_o), .port_col_oe_n(col_oe), .mac_tx_valid(tx_v), .mac_tx_nibble(tx_nib),
    .mac_tx_ready(tx_rdy), .mac_rx_valid(rx_v), .mac_rx_nibble(rx_nib), .mac_rx_dv(),
    .mac_crs(), .mac_col(), .status_mode(st_mode), .status_iface_on(on),
    .status_reserved(rsv), .status_full_duplex(fd), .fifth_port_internal_phy(int_phy));
  mpc_far_model i_far (.run(run), .strap(strap), .ck_o(ck_o), .ck_oe_n(ck_oe), .d_o(d_o),
    .d_oe_n(d_oe), .dv_o(dv_o), .ck_i(ck_i), .d_i(d_i), .din(din));
  // tx-side clock in antiphase, so the two directions use different edges
  assign tck_i = ~ck_i;
  // core clock
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  function automatic logic bad_code(input logic [3:0] c);
    return !c[3] && &c[1:0];
  endfunction
  task results;
    if (bad_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // strap both ports, pulse reset and check what was latched
  task boot(input logic [3:0] c0, input logic [3:0] c1, input logic d, input logic e);
    rstn <= 1'b0;
    strap <= {c1, c0};
    dis5 <= d;
    en6 <= e;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (8) @(posedge core_clk);
    `CHK("mode", {c1, c0}, st_mode)
    `CHK("on", {e & !bad_code(c1), !d & !bad_code(c0)}, on)
    `CHK("reserved", {e & bad_code(c1), !d & bad_code(c0)}, rsv)
    `CHK("internal phy", d, int_phy)
    `CHK("tx clock off", !(!d && (c0[3] ? c0[2] : !bad_code(c0))), tck_oe[0])
    if (!d && !bad_code(c0))
      `CHK("duplex", c0[3] ? c0[1] : c0[1:0] == 2'h2, fd[0])
  endtask
  // offer k random nibbles, each noted before it goes out
  task send(input int k);
    for (int i = 0; i < k; i++)
    begin
      exp = 4'($urandom);
      q.push_back(exp);
      tx_nib[0] <= exp;
      tx_v[0] <= 1'b1;
      n = 0;
      do
      begin
        @(negedge core_clk);
        n++;
      end
      while (!tx_rdy[0] && n < 600);
      if (n >= 600)
      begin
        bad_count++;
        results();
      end
      @(posedge core_clk);
    end
    tx_v[0] <= 1'b0;
    for (n = 0; q.size() != 0 && n < 2000; n++) @(posedge core_clk);
    if (q.size() != 0)
    begin
      bad_count++;
      results();
    end
  endtask
  // received nibbles against the oldest note
  always @(negedge core_clk)
    if (rx_v[0])
    begin
      exp = q.size() != 0 ? q.pop_front() : 4'hX;
      `CHK("rx nibble", exp, rx_nib[0])
    end
  // every strap code on the fifth port, random sixth port beside it
  initial
  begin
    rstn = 1'b0;
    en6 = 1'b0;
    dis5 = 1'b0;
    run = 1'b0;
    strap = '0;
    tx_v = '0;
    tx_nib = '0;
    bad_count = 0;
    checked = 0;
    void'($urandom(32'h54A99747));
    for (int c = 0; c < 16; c++)
    begin
      boot(4'(c), 4'($urandom), 1'b0, 1'($urandom));
      run <= c == 8 || c == 10;
      if (bad_code(4'(c)))
      begin
        tx_v[0] <= 1'b1;
        repeat (100) @(posedge core_clk);
        tx_v[0] <= 1'b0;
      end
      else
        send(3);
      run <= 1'b0;
    end
    boot(4'hF, 4'hD, 1'b1, 1'b1);
    results();
  end
endmodule
